// ---- rtl/slmc_top.sv ----
// control registers, irq, break/idle requests and sync clock for slmc
//
// Behaviour
// RULE_01: tx empty flag raises irq when enabled
// RULE_02: tx done flag raises irq when enabled
// RULE_03: overrun or rx full raises irq
// RULE_04: idle line flag raises irq when enabled
// RULE_05: tx_on enables transmitter, software read/write
// RULE_06: tx_on pulse while busy sends idle preamble
// RULE_07: one bit time delay after tx_on
// RULE_08: rx_on enables receiver, hunts start bit
// RULE_09: rx_mute selects mute, hardware wake clears
// RULE_10: software receives one byte before muting
// RULE_11: address mark: mute writes ignored while full
// RULE_12: break_send set then clear sends one break
// RULE_13: bit 7 kept clear, bits 5:4 zero
// RULE_14: break length from lin mode and format
// RULE_15: sync_clock_pin_on enables clock pin
// RULE_16: clock_polarity sets idle clock level
// RULE_17: clock_phase places edge mid or start
// RULE_18: final_bit_pulse gates last clock pulse
// RULE_19: last bit is msb, 8th or 9th
// RULE_20: no clock setting changes while tx enabled; the block still accepts such writes and samples them live
// RULE_21: single irq is or of enabled sources
// RULE_22: control registers reset to zero
`timescale 1ns/1ps
`include "slmc_cfg.svh"

module slmc_top #(
   parameter int ADDR_W = 12
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // status flags from the data path
   input wire logic tx_buffer_empty_flag,
   input wire logic transmit_done_flag,
   input wire logic rx_full_flag,
   input wire logic overrun_flag,
   input wire logic quiet_line_flag,
   // format and wake-up from the other control register
   input wire logic nine_bit_format,
   input wire logic address_mark_rouse,
   input wire logic wake_seen,
   // transmitter timing from the shifter
   input wire logic bit_tick,
   input wire logic tx_busy,
   input wire logic word_end,
   input wire logic data_window,
   input wire logic data_bit_start,
   input wire logic data_bit_mid,
   input wire logic data_bit_last,
   // controls to the data path
   output logic tx_run,
   output logic rx_run,
   output logic rx_mute_out,
   output logic idle_req,
   output logic break_req,
   output logic [3:0] break_len,
   // synchronous clock pin and irq
   output logic sclk_o,
   output logic sclk_oe,
   output logic serial_irq
);
   import slmc_pkg::*;

   // elaboration check: the map needs room for three words
   if (ADDR_W < 4) begin : g_bad_addr
      $error("slmc_top: ADDR_W too small for register map");
   end

   slmc_reg_t ctl_en_q, ctl_lc_q;
   slmc_tx_state_t tx_st_q;
   logic [31:0] prdata_q, rdata_d;
   logic [3:0] brk_len_q, brk_len_d;
   logic [7:0] wbyte;
   logic pready_q, pslverr_q, irq_q, tx_run_q, tick_seen_q;
   logic idle_pend_q, idle_req_q, brk_pend_q, brk_req_q;
   logic sclk_q, pulse_q, sclk_oe_q, tx_fell_q, rx_run_q, mute_q;
   logic wr_en, rd_en, hit_en, hit_lc, hit_st, mapped;
   logic tx_on, rx_on, mute, brk_bit, mute_lock;
   logic tx_on_fall, tx_on_rise, brk_fall, irq_d, pulse_keep;

   // field views
   assign tx_on = ctl_en_q[`SLMC_B_TX_ON];
   assign rx_on = ctl_en_q[`SLMC_B_RX_ON];
   assign mute = ctl_en_q[`SLMC_B_MUTE];
   assign brk_bit = ctl_en_q[`SLMC_B_BRK];

   // apb decode; writes land at the edge that samples pready high
   assign hit_en = paddr[ADDR_W-1:2] == `SLMC_OFF_ENABLES >> 2;
   assign hit_lc = paddr[ADDR_W-1:2] == `SLMC_OFF_LINCLK >> 2;
   assign hit_st = paddr[ADDR_W-1:2] == `SLMC_OFF_STATUS >> 2;
   assign mapped = hit_en | hit_lc | hit_st;
   assign wr_en = psel & penable & pready_q & pwrite & pstrb[0];
   assign rd_en = psel & penable & ~pready_q & ~pwrite;
   assign wbyte = pwdata[7:0];

   // address mark wake-up freezes mute while a byte waits
   assign mute_lock = address_mark_rouse & rx_full_flag; // RULE_11

   // edges of software writes on tx_on and break_send
   assign tx_on_fall = wr_en & hit_en & tx_on
      & ~wbyte[`SLMC_B_TX_ON];
   assign tx_on_rise = wr_en & hit_en & ~tx_on
      & wbyte[`SLMC_B_TX_ON];
   assign brk_fall = wr_en & hit_en & brk_bit
      & ~wbyte[`SLMC_B_BRK];

   // apb ready: one wait state, then answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else if (ce) begin
         pready_q <= psel & penable & ~pready_q;
      end
   end

   // read data and error captured in the wait state
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_en) begin
         rdata_d[7:0] = ctl_en_q;
      end else if (hit_lc) begin
         rdata_d[7:0] = ctl_lc_q & `SLMC_LINCLK_WMASK; // RULE_13
      end else if (hit_st) begin
         rdata_d[0] = tx_buffer_empty_flag;
         rdata_d[1] = transmit_done_flag;
         rdata_d[2] = rx_full_flag;
         rdata_d[3] = overrun_flag;
         rdata_d[4] = quiet_line_flag;
         rdata_d[5] = tx_st_q == SLMC_TX_RUN;
         rdata_d[6] = brk_pend_q;
         rdata_d[7] = idle_pend_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         if (psel & penable & ~pready_q) begin
            prdata_q <= rd_en ? rdata_d : 32'h0000_0000;
            pslverr_q <= ~mapped;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // first control register; hardware wake beats a software set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_en_q <= `SLMC_RST_ENABLES; // RULE_22
      end else if (ce) begin
         if (wr_en && hit_en) begin
            // irq enables, tx_on, rx_on, break are plain bits
            ctl_en_q[7:2] <= wbyte[7:2]; // RULE_05 RULE_08
            ctl_en_q[`SLMC_B_BRK] <= wbyte[`SLMC_B_BRK]; // RULE_12
            if (!mute_lock) begin
               ctl_en_q[`SLMC_B_MUTE] <= wbyte[`SLMC_B_MUTE]; // RULE_09
            end
         end
         // wake-up clears mute, also over a same-cycle write
         if (wake_seen && mute) begin
            ctl_en_q[`SLMC_B_MUTE] <= 1'b0; // RULE_09
         end
      end
   end

   // second control register; bit 7 and bits 5:4 never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_lc_q <= `SLMC_RST_LINCLK; // RULE_22
      end else if (ce) begin
         if (wr_en && hit_lc) begin
            ctl_lc_q <= wbyte & `SLMC_LINCLK_WMASK; // RULE_13
         end
      end
   end

   // start waits a whole bit time: first tick opens it, second ends it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_q <= SLMC_TX_OFF;
         tick_seen_q <= 1'b0;
      end else if (ce) begin
         tick_seen_q <= (tx_st_q == SLMC_TX_WAIT)
            & (tick_seen_q | bit_tick); // RULE_07
         case (tx_st_q)
            SLMC_TX_OFF: begin
               if (tx_on) begin
                  tx_st_q <= SLMC_TX_WAIT; // RULE_07
               end
            end
            SLMC_TX_WAIT: begin
               if (!tx_on) begin
                  tx_st_q <= SLMC_TX_OFF;
               end else if (bit_tick && tick_seen_q) begin
                  tx_st_q <= SLMC_TX_RUN; // RULE_07
               end
            end
            SLMC_TX_RUN: begin
               // a busy shifter finishes its word before stopping
               if (!tx_on && !tx_busy) begin
                  tx_st_q <= SLMC_TX_OFF; // RULE_05
               end
            end
            default: begin
               tx_st_q <= SLMC_TX_OFF;
            end
         endcase
      end
   end

   // transmitter run level towards the shifter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_run_q <= 1'b0;
      end else if (ce) begin
         tx_run_q <= (tx_st_q == SLMC_TX_RUN) & (tx_on | tx_busy);
      end
   end

   // tx_on low-then-high during a word arms an idle preamble;
   // the fall alone is remembered until the shifter goes idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_fell_q <= 1'b0;
         idle_pend_q <= 1'b0;
      end else if (ce) begin
         if (tx_on_fall && tx_busy) begin
            tx_fell_q <= 1'b1;
         end else if (!tx_busy) begin
            tx_fell_q <= 1'b0;
         end
         if (tx_on_rise && (tx_fell_q || tx_busy)) begin
            idle_pend_q <= 1'b1; // RULE_06
         end else if (idle_req_q) begin
            idle_pend_q <= 1'b0;
         end
      end
   end

   // preamble issued once the current word completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_req_q <= 1'b0;
      end else if (ce) begin
         idle_req_q <= idle_pend_q & ~idle_req_q
            & (word_end | ~tx_busy) & tx_on; // RULE_06
      end
   end

   // break_send set then cleared arms exactly one break word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_pend_q <= 1'b0;
      end else if (ce) begin
         if (brk_fall) begin
            brk_pend_q <= 1'b1; // RULE_12
         end else if (brk_req_q) begin
            brk_pend_q <= 1'b0;
         end
      end
   end

   // break leaves after the current word; idle goes first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_req_q <= 1'b0;
      end else if (ce) begin
         brk_req_q <= brk_pend_q & ~brk_req_q & ~idle_pend_q
            & (word_end | ~tx_busy)
            & (tx_st_q == SLMC_TX_RUN); // RULE_12
      end
   end

   // break low phase length from lin mode and word format
   always_comb begin
      case ({ctl_lc_q[`SLMC_B_LIN], nine_bit_format})
         2'b00: brk_len_d = `SLMC_BRK_STD8; // RULE_14
         2'b01: brk_len_d = `SLMC_BRK_STD9; // RULE_14
         2'b10: brk_len_d = `SLMC_BRK_LIN8; // RULE_14
         2'b11: brk_len_d = `SLMC_BRK_LIN9; // RULE_14
         default: brk_len_d = `SLMC_BRK_STD8;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_len_q <= `SLMC_BRK_STD8;
      end else if (ce) begin
         brk_len_q <= brk_len_d;
      end
   end

   // msb pulse kept only when final_bit_pulse is set
   assign pulse_keep = ~data_bit_last | ctl_lc_q[`SLMC_B_LBP]; // RULE_18 RULE_19

   // clock pulse: high half of a data bit, which half set by phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= 1'b0;
      end else if (ce) begin
         if (!data_window) begin
            pulse_q <= 1'b0;
         end else if (data_bit_start) begin
            pulse_q <= ctl_lc_q[`SLMC_B_CLOCK_PHASE] & pulse_keep; // RULE_17
         end else if (data_bit_mid) begin
            pulse_q <= ~ctl_lc_q[`SLMC_B_CLOCK_PHASE] & pulse_keep; // RULE_17
         end
      end
   end

   // pin level: polarity outside the window, pulse xor polarity within
   // settings are sampled live, so changes with tx on glitch the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         sclk_oe_q <= 1'b0;
      end else if (ce) begin
         sclk_q <= ctl_lc_q[`SLMC_B_CLOCK_POLARITY] ^ pulse_q; // RULE_16 RULE_20
         sclk_oe_q <= ctl_lc_q[`SLMC_B_CKEN]; // RULE_15
      end
   end

   // one irq line from every enabled, still-set source
   always_comb begin
      irq_d = 1'b0;
      if (ctl_en_q[`SLMC_B_TXE_IRQ] && tx_buffer_empty_flag) begin
         irq_d = 1'b1; // RULE_01
      end
      if (ctl_en_q[`SLMC_B_TXD_IRQ] && transmit_done_flag) begin
         irq_d = 1'b1; // RULE_02
      end
      if (ctl_en_q[`SLMC_B_RX_IRQ]
            && (overrun_flag || rx_full_flag)) begin
         irq_d = 1'b1; // RULE_03
      end
      if (ctl_en_q[`SLMC_B_QL_IRQ] && quiet_line_flag) begin
         irq_d = 1'b1; // RULE_04
      end
   end

   // level held while any enabled flag stays set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= irq_d; // RULE_21
      end
   end

   // receiver controls are register bits; the receiver hunts
   // for a start bit from the first cycle rx_run is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_run_q <= 1'b0;
         mute_q <= 1'b0;
      end else if (ce) begin
         rx_run_q <= rx_on; // RULE_08
         mute_q <= mute; // RULE_09
      end
   end

   // outputs, all from flip-flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_run = tx_run_q;
   assign rx_run = rx_run_q;
   assign rx_mute_out = mute_q;
   assign idle_req = idle_req_q;
   assign break_req = brk_req_q;
   assign break_len = brk_len_q;
   assign sclk_o = sclk_q;
   assign sclk_oe = sclk_oe_q;
   assign serial_irq = irq_q;

endmodule

// ---- common/slmc_cfg.svh ----
// register map, field positions, reset values and counts for slmc
`ifndef SLMC_CFG_SVH
`define SLMC_CFG_SVH

// register byte offsets
`define SLMC_OFF_ENABLES 12'h000
`define SLMC_OFF_LINCLK 12'h004
`define SLMC_OFF_STATUS 12'h008

// serial_ctrl_enables fields
`define SLMC_B_TXE_IRQ 7
`define SLMC_B_TXD_IRQ 6
`define SLMC_B_RX_IRQ 5
`define SLMC_B_QL_IRQ 4
`define SLMC_B_TX_ON 3
`define SLMC_B_RX_ON 2
`define SLMC_B_MUTE 1
`define SLMC_B_BRK 0

// serial_ctrl_lin_clock fields
`define SLMC_B_LIN 6
`define SLMC_B_CKEN 3
`define SLMC_B_CLOCK_POLARITY 2
`define SLMC_B_CLOCK_PHASE 1
`define SLMC_B_LBP 0
`define SLMC_LINCLK_WMASK 8'h4F

// reset values
`define SLMC_RST_ENABLES 8'h00
`define SLMC_RST_LINCLK 8'h00

// break low phase lengths in bits
`define SLMC_BRK_STD8 4'hA
`define SLMC_BRK_STD9 4'hB
`define SLMC_BRK_LIN8 4'hD
`define SLMC_BRK_LIN9 4'hE

`endif

// ---- common/slmc_pkg.sv ----
// types shared by the serial lin master control block
package slmc_pkg;

   // transmitter enable sequencing
   typedef enum logic [1:0] {
      SLMC_TX_OFF,
      SLMC_TX_WAIT,
      SLMC_TX_RUN
   } slmc_tx_state_t;

   typedef logic [7:0] slmc_reg_t;

endpackage

// ---- verif/slmc_properties.sv ----
// assertion checker for the slmc control block, bound to its top
`timescale 1ns/1ps
module slmc_checker #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   // flags and shifter timing
   input wire logic tx_buffer_empty_flag,
   input wire logic transmit_done_flag,
   input wire logic rx_full_flag,
   input wire logic overrun_flag,
   input wire logic quiet_line_flag,
   input wire logic nine_bit_format,
   input wire logic bit_tick,
   input wire logic tx_busy,
   input wire logic word_end,
   input wire logic data_window,
   // block outputs
   input wire logic tx_run,
   input wire logic rx_run,
   input wire logic idle_req,
   input wire logic break_req,
   input wire logic [3:0] break_len,
   input wire logic sclk_o,
   input wire logic sclk_oe,
   input wire logic serial_irq
);
   logic [7:0] en_q, lc_q;
   logic wr_ok, irq_exp;
   logic [3:0] blen_exp;
   // a write lands at the edge where the slave answers
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
   assign irq_exp = (en_q[7] && tx_buffer_empty_flag)
      || (en_q[6] && transmit_done_flag)
      || (en_q[5] && (overrun_flag || rx_full_flag))
      || (en_q[4] && quiet_line_flag);
   assign blen_exp = lc_q[6] ? (nine_bit_format ? 4'hE : 4'hD)
      : (nine_bit_format ? 4'hB : 4'hA);
   // shadow registers; mute bit copied but never checked, hardware may clear it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 8'h00;
         lc_q <= 8'h00;
      end else if (wr_ok && paddr[ADDR_W-1:2] == '0) begin
         en_q <= pwdata[7:0];
      end else if (wr_ok && paddr[ADDR_W-1:2] == (ADDR_W-2)'(1)) begin
         lc_q <= pwdata[7:0] & 8'h4F;
      end
   end
   // bit ticks seen since tx_on was set, saturating at three
   logic [1:0] tk_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tk_q <= 2'h0;
      end else if (!en_q[3] || tx_run) begin
         tk_q <= 2'h0;
      end else if (bit_tick && tk_q != 2'h3) begin
         tk_q <= tk_q + 2'h1;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence run_start_s;
      !tx_run ##1 tx_run;
   endsequence
   irq_or_a: assert property (
      $past(presetn) |-> serial_irq == $past(irq_exp))
      else $error("irq differs from enabled flags");
   brk_len_a: assert property (
      $past(presetn) |-> break_len == $past(blen_exp))
      else $error("break length wrong");
   rx_follow_a: assert property (
      rx_run == $past(en_q[2]))
      else $error("rx_run does not follow rx_on");
   clk_pin_a: assert property (
      sclk_oe == $past(lc_q[3]))
      else $error("clock pin enable wrong");
   clk_idle_a: assert property (
      !data_window [*3] |-> sclk_o == $past(lc_q[2]))
      else $error("idle clock level wrong");
   brk_slot_a: assert property (
      break_req |-> $past(!tx_busy || word_end) ##1 !break_req)
      else $error("break request misplaced");
   idle_slot_a: assert property (
      idle_req |-> $past(!tx_busy || word_end) ##1 !idle_req)
      else $error("idle request misplaced");
   tx_delay_a: assert property (
      run_start_s |-> $past(bit_tick, 2))
      else $error("transmitter ran before a bit time");
   tx_gap_a: assert property (
      run_start_s |-> $past(tk_q) >= 2'h2)
      else $error("transmitter ran within one bit time");
endmodule
bind slmc_top slmc_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
   .tx_buffer_empty_flag, .transmit_done_flag, .rx_full_flag,
   .overrun_flag, .quiet_line_flag, .nine_bit_format, .bit_tick,
   .tx_busy, .word_end, .data_window, .tx_run, .rx_run, .idle_req,
   .break_req, .break_len, .sclk_o, .sclk_oe, .serial_irq);

// ---- verif/slmc_shifter_model.sv ----
// behavioural shifter that stands on the far side of the block
`timescale 1ns/1ps
module slmc_shifter_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // word request
   input wire logic go,
   input wire logic tx_run,
   // timing to the block
   output logic bit_tick,
   output logic tx_busy,
   output logic word_end,
   output logic data_window,
   output logic data_bit_start,
   output logic data_bit_mid,
   output logic data_bit_last
);
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   // free running phase, four clocks per bit keeps runs short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= 2'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
      end
   end
   // start bit, eight data bits, stop bit; starts only on a bit edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy <= 1'b0;
         bit_q <= 4'h0;
      end else if (!tx_busy) begin
         tx_busy <= go && tx_run && ph_q == 2'h3;
         bit_q <= 4'h0;
      end else if (ph_q == 2'h3) begin
         bit_q <= bit_q + 4'h1;
         tx_busy <= bit_q != 4'h9;
      end
   end
   // strobes derived from phase and bit index
   assign bit_tick = ph_q == 2'h0;
   assign data_window = tx_busy && bit_q >= 4'h1 && bit_q <= 4'h8;
   assign data_bit_start = data_window && ph_q == 2'h0;
   assign data_bit_mid = data_window && ph_q == 2'h2;
   assign data_bit_last = data_window && bit_q == 4'h8;
   assign word_end = tx_busy && bit_q == 4'h9 && ph_q == 2'h3;
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the slmc control block
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, go = 1'b0, nine_bit_format = 1'b0;
   logic address_mark_rouse = 1'b0, wake_seen = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF, break_len;
   logic [4:0] flg = 5'h00;
   logic pready, pslverr, bit_tick, tx_busy, word_end, data_window;
   logic data_bit_start, data_bit_mid, data_bit_last, tx_run, rx_run;
   logic rx_mute_out, idle_req, break_req, sclk_o, sclk_oe, serial_irq;
   int err_count = 0, num_checks = 0, n;
   slmc_top u_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .tx_buffer_empty_flag(flg[0]), .transmit_done_flag(flg[1]),
      .rx_full_flag(flg[2]), .overrun_flag(flg[3]),
      .quiet_line_flag(flg[4]), .nine_bit_format, .address_mark_rouse,
      .wake_seen, .bit_tick, .tx_busy, .word_end, .data_window,
      .data_bit_start, .data_bit_mid, .data_bit_last, .tx_run, .rx_run,
      .rx_mute_out, .idle_req, .break_req, .break_len, .sclk_o, .sclk_oe,
      .serial_irq);
   slmc_shifter_model u_model (.pclk, .presetn, .go, .tx_run, .bit_tick,
      .tx_busy, .word_end, .data_window, .data_bit_start, .data_bit_mid,
      .data_bit_last);
   always #12.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one apb transfer; the wait for pready is bounded
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   function automatic logic pick(input int k);
      return k == 0 ? idle_req : k == 1 ? break_req : k == 2 ? tx_run
         : tx_busy;
   endfunction
   task automatic wait_out(input int k);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pick(k) !== 1'b1 && n < 100);
      chk(n < 100, 1'b1);
   endtask
   task automatic t_regs();
      rdc(12'h000, 8'h00);
      rdc(12'h004, 8'h00);
      apb(1'b1, 12'h000, 8'hF4);
      rdc(12'h000, 8'hF4);
      chk(rx_run, 1'b1);
      apb(1'b1, 12'h000, 8'h08);
      rdc(12'h000, 8'h08);
      chk(rx_run, 1'b0);
      apb(1'b1, 12'h004, 8'hFF);
      rdc(12'h004, 8'h4F);
      pstrb <= 4'h0;
      apb(1'b1, 12'h004, 8'h00);
      pstrb <= 4'hF;
      rdc(12'h004, 8'h4F);
      apb(1'b0, 12'h010, 8'h00);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, 12'h004, 8'h00);
   endtask
   task automatic t_irq();
      logic [7:0] m [5] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10};
      for (int f = 0; f < 5; f++) begin
         apb(1'b1, 12'h000, m[f]);
         flg <= 5'(1 << f);
         repeat (3) @(posedge pclk);
         chk(serial_irq, 1'b1);
         rdc(12'h008, 8'(1 << f));
         apb(1'b1, 12'h000, ~m[f] & 8'hF0);
         repeat (3) @(posedge pclk);
         chk(serial_irq, 1'b0);
         flg <= 5'h00;
      end
   endtask
   task automatic t_blen();
      logic [3:0] tab [4] = '{4'hA, 4'hB, 4'hD, 4'hE};
      for (int i = 0; i < 4; i++) begin
         nine_bit_format <= i[0];
         apb(1'b1, 12'h004, {1'b0, i[1], 6'h00});
         repeat (2) @(posedge pclk);
         chk(break_len, tab[i]);
      end
      nine_bit_format <= 1'b0;
      apb(1'b1, 12'h004, 8'h00);
   endtask
   task automatic t_mute();
      flg <= 5'h04; // a byte is received before muting
      address_mark_rouse <= 1'b1;
      apb(1'b1, 12'h000, 8'h02);
      rdc(12'h000, 8'h00);
      address_mark_rouse <= 1'b0;
      flg <= 5'h00;
      apb(1'b1, 12'h000, 8'h02);
      rdc(12'h000, 8'h02);
      chk(rx_mute_out, 1'b1);
      wake_seen <= 1'b1;
      @(posedge pclk);
      wake_seen <= 1'b0;
      rdc(12'h000, 8'h00);
   endtask
   task automatic t_tx();
      apb(1'b1, 12'h000, 8'h08);
      wait_out(2);
      apb(1'b1, 12'h000, 8'h09);
      apb(1'b1, 12'h000, 8'h08);
      wait_out(1);
      go <= 1'b1;
      wait_out(3);
      go <= 1'b0;
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b1, 12'h000, 8'h08);
      chk(tx_busy, 1'b1);
      wait_out(0);
      chk(tx_busy, 1'b0);
   endtask
   task automatic t_sclk();
      int p;
      logic l;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 12'h000, 8'h00); // transmitter off first
         apb(1'b1, 12'h004, 8'h08 | 8'(i));
         apb(1'b1, 12'h000, 8'h08);
         chk(sclk_oe, 1'b1);
         wait_out(2);
         go <= 1'b1;
         wait_out(3);
         go <= 1'b0;
         p = 0;
         l = sclk_o;
         repeat (48) begin
            @(posedge pclk);
            p += int'((sclk_o ^ i[2]) && !(l ^ i[2]));
            l = sclk_o;
         end
         chk(p, 7 + i[0]);
         chk(sclk_o, i[2]);
      end
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b1, 12'h004, 8'h00);
   endtask
   task automatic end_of_test();
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_irq();
      t_blen();
      t_mute();
      t_tx();
      t_sclk();
      end_of_test();
   end
   // watchdog at 20000 cycles, far beyond the under one thousand cycles the tests need
   initial begin
      #500000;
      err_count++;
      end_of_test();
   end
endmodule
